/* design/rate_codec_pkg.sv */
// constants shared by the rate group encoder, decoder and bench
// assumes one 100 MHz clock; octets move one per cycle on the link
package rate_codec_pkg;

  // ----------------------------------------------------------------
  // octet layout of one rate group
  // ----------------------------------------------------------------
  localparam int unsigned OCTETS_PER_GROUP = 4;
  localparam int unsigned RATE_W           = 7;
  localparam int unsigned LOW_W            = 6;
  localparam int unsigned MIN_HI_BIT       = 0;   // octet bit 1
  localparam int unsigned MAX_HI_BIT       = 1;   // octet bit 2
  localparam int unsigned STEP_HI_BIT      = 2;   // octet bit 3
  localparam logic [1:0]  POS_HI           = 2'h0;
  localparam logic [1:0]  POS_MIN          = 2'h1;
  localparam logic [1:0]  POS_MAX          = 2'h2;
  localparam logic [1:0]  POS_STEP         = 2'h3;

  // base group plus extended groups
  localparam int unsigned MAX_GROUPS       = 8;
  localparam int unsigned GRP_W            = 3;

  // ----------------------------------------------------------------
  // encoder registers, byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0]  CTRL_OFS         = 8'h00;
  localparam logic [7:0]  STATUS_OFS       = 8'h04;
  localparam logic [7:0]  TABLE_OFS        = 8'h10;
  localparam int unsigned CTRL_START_BIT   = 0;
  localparam int unsigned CTRL_CNT_LSB     = 4;
  localparam int unsigned STAT_BUSY_BIT    = 0;
  localparam int unsigned STAT_DONE_BIT    = 1;
  localparam int unsigned TBL_MIN_LSB      = 0;
  localparam int unsigned TBL_MAX_LSB      = 8;
  localparam int unsigned TBL_STEP_LSB     = 16;
  localparam logic [2:0]  CNT_RESET        = 3'h0;
  localparam logic [1:0]  HTRANS_NONSEQ    = 2'h2;
  localparam logic [2:0]  HSIZE_WORD       = 3'h2;

  typedef struct packed {
    logic [RATE_W-1:0] step;
    logic [RATE_W-1:0] max;
    logic [RATE_W-1:0] min;
  } rate_group_t;

endpackage : rate_codec_pkg

/* design/rate_link_if.sv */
// octet link between the encoding end and the decoding end
// assumes both ends share hclk; no back-pressure on the link
`timescale 1ns/1ps
`default_nettype none

interface rate_link_if;
  logic       oct_valid;
  logic [7:0] oct_data;
  logic       oct_last;

  modport tx (output oct_valid, output oct_data, output oct_last);
  modport rx (input oct_valid, input oct_data, input oct_last);
endinterface : rate_link_if

`default_nettype wire

/* design/rate_group_encoder.sv */
// encoding end: software fills a table of rate groups over ahb-lite,
// then starts a block; groups leave as four octets each on the link
// assumes an ahb-lite master and the decoding end on the same hclk
//
// Notes on behaviour
// - first octet bits 1-3 carry min/max/step msb
// - first octet bits 4-6 reserved, no meaning
// - base second octet: minimum low six bits
// - base third octet: maximum low six bits
// - base fourth octet: step low six bits
// - values are seven bits, msb above six
// - extended group j fills octets j*4+1..j*4+4
// - extended group last octet: step low bits
//
// Our own choices: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module rate_group_encoder
  import rate_codec_pkg::*;
(
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // octet link
  rate_link_if.tx          link
);

  // ----------------------------------------------------------------
  // octet formatting
  // ----------------------------------------------------------------
  function automatic logic [7:0] encode_octet(input rate_group_t g, input logic [1:0] pos);
    logic [7:0] o;
    o = 8'h00;
    unique case (pos)
      POS_HI: begin
        // reserved bits and top two stay zero
        o[MIN_HI_BIT]  = g.min[RATE_W-1];
        o[MAX_HI_BIT]  = g.max[RATE_W-1];
        o[STEP_HI_BIT] = g.step[RATE_W-1];
      end
      POS_MIN:  o[LOW_W-1:0] = g.min[LOW_W-1:0];
      POS_MAX:  o[LOW_W-1:0] = g.max[LOW_W-1:0];
      POS_STEP: o[LOW_W-1:0] = g.step[LOW_W-1:0];
    endcase
    return o;
  endfunction

  function automatic logic tbl_hit(input logic [7:0] a);
    return (a >= TABLE_OFS) && (a < TABLE_OFS + 8'(4 * MAX_GROUPS)) && (a[1:0] == 2'h0);
  endfunction

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  logic             dp_valid_q, dp_valid_d;
  logic             dp_write_q, dp_write_d;
  logic [7:0]       dp_addr_q,  dp_addr_d;
  logic             rd_wait_q,  rd_wait_d;
  logic [31:0]      rdata_q,    rdata_d;
  rate_group_t      tbl_q [MAX_GROUPS];
  rate_group_t      tbl_d [MAX_GROUPS];
  logic [GRP_W-1:0] cnt_q,      cnt_d;
  logic             done_q,     done_d;
  logic             start_req;
  logic             addr_take;
  logic             wr_take;
  logic             finish;
  logic             busy;
  logic [GRP_W-1:0] tbl_idx;

  // reads take one wait state so a write just before is visible
  assign addr_take = hsel && hready && (htrans == HTRANS_NONSEQ) && (hsize == HSIZE_WORD);
  assign wr_take   = dp_valid_q && dp_write_q;
  assign tbl_idx   = GRP_W'((dp_addr_q - TABLE_OFS) >> 2);
  assign hreadyout = !(dp_valid_q && !dp_write_q && !rd_wait_q);
  assign hrdata    = rdata_q;
  assign hresp     = 1'b0;
  assign start_req = wr_take && (dp_addr_q == CTRL_OFS) && hwdata[CTRL_START_BIT] && !busy;

  always_comb begin
    dp_valid_d = dp_valid_q;
    dp_write_d = dp_write_q;
    dp_addr_d  = dp_addr_q;
    rd_wait_d  = 1'b0;
    rdata_d    = rdata_q;
    tbl_d      = tbl_q;
    cnt_d      = cnt_q;
    done_d     = done_q;
    if (hready) begin
      dp_valid_d = addr_take;
      dp_write_d = hwrite;
      dp_addr_d  = haddr[7:0];
    end
    if (dp_valid_q && !dp_write_q && !rd_wait_q) begin
      rd_wait_d = 1'b1;
      rdata_d   = 32'h0000_0000;
      if (dp_addr_q == CTRL_OFS) begin
        rdata_d[CTRL_CNT_LSB +: GRP_W] = cnt_q;
      end else if (dp_addr_q == STATUS_OFS) begin
        rdata_d[STAT_BUSY_BIT] = busy;
        rdata_d[STAT_DONE_BIT] = done_q;
      end else if (tbl_hit(dp_addr_q)) begin
        rdata_d[TBL_MIN_LSB +: RATE_W]  = tbl_q[tbl_idx].min;
        rdata_d[TBL_MAX_LSB +: RATE_W]  = tbl_q[tbl_idx].max;
        rdata_d[TBL_STEP_LSB +: RATE_W] = tbl_q[tbl_idx].step;
      end
    end
    // table and count are frozen while a block is on the link
    if (wr_take && !busy) begin
      if (dp_addr_q == CTRL_OFS) begin
        cnt_d = hwdata[CTRL_CNT_LSB +: GRP_W];
      end else if (tbl_hit(dp_addr_q)) begin
        tbl_d[tbl_idx].min  = hwdata[TBL_MIN_LSB +: RATE_W];
        tbl_d[tbl_idx].max  = hwdata[TBL_MAX_LSB +: RATE_W];
        tbl_d[tbl_idx].step = hwdata[TBL_STEP_LSB +: RATE_W];
      end
    end
    if (wr_take && (dp_addr_q == STATUS_OFS) && hwdata[STAT_DONE_BIT]) begin
      done_d = 1'b0;
    end
    // completion beats a clear in the same cycle
    if (finish) begin
      done_d = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_valid_q <= 1'b0;
      dp_write_q <= 1'b0;
      dp_addr_q  <= 8'h00;
      rd_wait_q  <= 1'b0;
      rdata_q    <= 32'h0000_0000;
      cnt_q      <= CNT_RESET;
      done_q     <= 1'b0;
      for (int i = 0; i < MAX_GROUPS; i++) begin
        tbl_q[i] <= '0;
      end
    end else begin
      dp_valid_q <= dp_valid_d;
      dp_write_q <= dp_write_d;
      dp_addr_q  <= dp_addr_d;
      rd_wait_q  <= rd_wait_d;
      rdata_q    <= rdata_d;
      cnt_q      <= cnt_d;
      done_q     <= done_d;
      tbl_q      <= tbl_d;
    end
  end

  // ----------------------------------------------------------------
  // octet sender
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    TX_IDLE = 1'b0,
    TX_SEND = 1'b1
  } tx_state_t;

  tx_state_t        st_q,    st_d;
  logic [GRP_W-1:0] grp_q,   grp_d;
  logic [1:0]       pos_q,   pos_d;
  logic [GRP_W-1:0] last_q,  last_d;
  logic             valid_q, valid_d;
  logic [7:0]       data_q,  data_d;
  logic             olast_q, olast_d;

  assign busy   = (st_q == TX_SEND);
  assign finish = busy && (pos_q == POS_STEP) && (grp_q == last_q);

  always_comb begin
    st_d    = st_q;
    grp_d   = grp_q;
    pos_d   = pos_q;
    last_d  = last_q;
    valid_d = 1'b0;
    data_d  = data_q;
    olast_d = 1'b0;
    unique case (st_q)
      TX_IDLE: begin
        if (start_req) begin
          st_d   = TX_SEND;
          grp_d  = '0;                 // base group leads
          pos_d  = POS_HI;
          last_d = hwdata[CTRL_CNT_LSB +: GRP_W];  // count written with start applies now
        end
      end
      TX_SEND: begin
        valid_d = 1'b1;
        data_d  = encode_octet(tbl_q[grp_q], pos_q);
        olast_d = finish;
        pos_d   = pos_q + 2'h1;
        if (pos_q == POS_STEP) begin
          grp_d = grp_q + 3'h1;        // ascending group order
          if (finish) begin
            st_d = TX_IDLE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q    <= TX_IDLE;
      grp_q   <= '0;
      pos_q   <= POS_HI;
      last_q  <= '0;
      valid_q <= 1'b0;
      data_q  <= 8'h00;
      olast_q <= 1'b0;
    end else begin
      st_q    <= st_d;
      grp_q   <= grp_d;
      pos_q   <= pos_d;
      last_q  <= last_d;
      valid_q <= valid_d;
      data_q  <= data_d;
      olast_q <= olast_d;
    end
  end

  assign link.oct_valid = valid_q;
  assign link.oct_data  = data_q;
  assign link.oct_last  = olast_q;

endmodule // rate_group_encoder

`default_nettype wire

/* design/rate_group_decoder.sv */
// decoding end: splits the octet stream into rate groups and rebuilds
// the seven-bit minimum, maximum and step of each group
// assumes the encoding end on the same hclk, so no synchroniser
`timescale 1ns/1ps
`default_nettype none

module rate_group_decoder
  import rate_codec_pkg::*;
(
  // clock and reset
  input  wire logic         hclk,
  input  wire logic         hresetn,
  // octet link
  rate_link_if.rx           link,
  // decoded groups
  output logic              rate_valid,
  output logic [GRP_W-1:0]  rate_group,
  output logic [RATE_W-1:0] rate_min,
  output logic [RATE_W-1:0] rate_max,
  output logic [RATE_W-1:0] rate_step,
  // block status
  output logic              block_done,
  output logic              block_error
);

  logic [1:0]        pos_q,   pos_d;
  logic [GRP_W-1:0]  grp_q,   grp_d;
  logic [2:0]        hi_q,    hi_d;
  logic [LOW_W-1:0]  lmin_q,  lmin_d;
  logic [LOW_W-1:0]  lmax_q,  lmax_d;
  logic              val_q,   val_d;
  logic [GRP_W-1:0]  ogrp_q,  ogrp_d;
  logic [RATE_W-1:0] omin_q,  omin_d;
  logic [RATE_W-1:0] omax_q,  omax_d;
  logic [RATE_W-1:0] ostep_q, ostep_d;
  logic              done_q,  done_d;
  logic              err_q,   err_d;

  always_comb begin
    pos_d   = pos_q;
    grp_d   = grp_q;
    hi_d    = hi_q;
    lmin_d  = lmin_q;
    lmax_d  = lmax_q;
    val_d   = 1'b0;
    ogrp_d  = ogrp_q;
    omin_d  = omin_q;
    omax_d  = omax_q;
    ostep_d = ostep_q;
    done_d  = 1'b0;
    err_d   = 1'b0;
    if (link.oct_valid) begin
      pos_d = pos_q + 2'h1;
      unique case (pos_q)
        // reserved bits and top two are never looked at
        POS_HI:  hi_d = {link.oct_data[STEP_HI_BIT], link.oct_data[MAX_HI_BIT],
                         link.oct_data[MIN_HI_BIT]};
        POS_MIN: lmin_d = link.oct_data[LOW_W-1:0];
        POS_MAX: lmax_d = link.oct_data[LOW_W-1:0];
        POS_STEP: begin
          val_d   = 1'b1;
          ogrp_d  = grp_q;
          omin_d  = {hi_q[0], lmin_q};
          omax_d  = {hi_q[1], lmax_q};
          ostep_d = {hi_q[2], link.oct_data[LOW_W-1:0]};
          grp_d   = grp_q + 3'h1;
        end
      endcase
      if (link.oct_last) begin
        // a block cut short mid-group drops that group
        done_d = 1'b1;
        err_d  = (pos_q != POS_STEP);
        pos_d  = POS_HI;
        grp_d  = '0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pos_q   <= POS_HI;
      grp_q   <= '0;
      hi_q    <= 3'h0;
      lmin_q  <= '0;
      lmax_q  <= '0;
      val_q   <= 1'b0;
      ogrp_q  <= '0;
      omin_q  <= '0;
      omax_q  <= '0;
      ostep_q <= '0;
      done_q  <= 1'b0;
      err_q   <= 1'b0;
    end else begin
      pos_q   <= pos_d;
      grp_q   <= grp_d;
      hi_q    <= hi_d;
      lmin_q  <= lmin_d;
      lmax_q  <= lmax_d;
      val_q   <= val_d;
      ogrp_q  <= ogrp_d;
      omin_q  <= omin_d;
      omax_q  <= omax_d;
      ostep_q <= ostep_d;
      done_q  <= done_d;
      err_q   <= err_d;
    end
  end

  assign rate_valid  = val_q;
  assign rate_group  = ogrp_q;
  assign rate_min    = omin_q;
  assign rate_max    = omax_q;
  assign rate_step   = ostep_q;
  assign block_done  = done_q;
  assign block_error = err_q;

endmodule // rate_group_decoder

`default_nettype wire

/* verification/rate_codec_asserts.sv */
// checker for the octet link and the groups rebuilt from it
// assumes one hclk domain; instantiated beside the link by the bench
`timescale 1ns/1ps
`default_nettype none

module rate_codec_asserts (
  // clock and reset
  input wire logic       hclk,
  input wire logic       hresetn,
  // octet link
  input wire logic       oct_valid,
  input wire logic [7:0] oct_data,
  input wire logic       oct_last,
  // decoded groups
  input wire logic       rate_valid,
  input wire logic [2:0] rate_group,
  input wire logic [6:0] rate_min,
  input wire logic [6:0] rate_max,
  input wire logic [6:0] rate_step,
  input wire logic       block_done,
  input wire logic       block_error
);
  // ----------------------------------------
  // octet position and captured octets
  // ----------------------------------------
  logic [1:0] pos_q;
  logic [2:0] grp_q;
  logic [7:0] hi_q, min_q, max_q, lo_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pos_q <= 2'h0;
      grp_q <= 3'h0;
      hi_q  <= 8'h00;
      min_q <= 8'h00;
      max_q <= 8'h00;
      lo_q  <= 8'h00;
    end else if (oct_valid) begin
      pos_q <= oct_last ? 2'h0 : pos_q + 2'h1;
      grp_q <= oct_last ? 3'h0 : (pos_q == 2'h3) ? grp_q + 3'h1 : grp_q;
      hi_q  <= (pos_q == 2'h0) ? oct_data : hi_q;
      min_q <= (pos_q == 2'h1) ? oct_data : min_q;
      max_q <= (pos_q == 2'h2) ? oct_data : max_q;
      lo_q  <= oct_data;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_reserved_zero: assert property (oct_valid && pos_q == 2'h0 |-> oct_data[7:3] == 5'h0)
    else $error("reserved bits set in first octet");
  a_low_six_only: assert property (oct_valid && pos_q != 2'h0 |-> oct_data[7:6] == 2'h0)
    else $error("low octet wider than six bits");
  a_last_on_fourth: assert property (oct_valid && oct_last |-> pos_q == 2'h3)
    else $error("block ended inside a group");
  a_octets_contiguous: assert property (oct_valid && !oct_last |=> oct_valid)
    else $error("gap inside a block");
  a_min_rebuilt: assert property (oct_valid && pos_q == 2'h3 |=> rate_valid && rate_min == {hi_q[0], min_q[5:0]})
    else $error("minimum rebuilt wrongly");
  a_max_rebuilt: assert property (oct_valid && pos_q == 2'h3 |=> rate_max == {hi_q[1], max_q[5:0]})
    else $error("maximum rebuilt wrongly");
  a_step_rebuilt: assert property (oct_valid && pos_q == 2'h3 |=> rate_step == {hi_q[2], lo_q[5:0]})
    else $error("step rebuilt wrongly");
  a_group_order: assert property (oct_valid && pos_q == 2'h3 |=> rate_group == $past(grp_q))
    else $error("group index out of order");
  a_valid_cause: assert property (rate_valid |-> $past(oct_valid) && $past(pos_q) == 2'h3)
    else $error("group reported without its fourth octet");
  a_done_clean: assert property (oct_valid && oct_last |=> block_done && !block_error)
    else $error("clean block not closed cleanly");
  c_full_block: cover property (oct_valid && oct_last && grp_q == 3'h7);
  c_base_group: cover property (rate_valid && rate_group == 3'h0);
  c_done: cover property (block_done);
endmodule // rate_codec_asserts

`default_nettype wire

/* verification/tb_downstream_rate_field_codec.sv */
// bench: encoder and decoder across one link, a second decoder fed by a rogue driver
// assumes package and link interface compiled first
`timescale 1ns/1ps
`default_nettype none

module tb_downstream_rate_field_codec;
  import rate_codec_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd_s;
  logic [1:0]  htrans;
  logic [2:0]  hsize, last, rg, rg2;
  logic        rv, bd, be, rv2, bd2, be2;
  logic [6:0]  rmin, rmax, rstp, rmin2, rmax2, rstp2;
  int          n_mismatch, checks, cyc, exp_g, exp_w, dones;
  rate_group_t tbl [8];
  rate_link_if link ();
  rate_link_if bad ();

  rate_group_encoder i_rate_group_encoder (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .link(link));
  rate_group_decoder i_rate_group_decoder (.hclk(hclk), .hresetn(hresetn), .link(link),
    .rate_valid(rv), .rate_group(rg), .rate_min(rmin), .rate_max(rmax), .rate_step(rstp),
    .block_done(bd), .block_error(be));
  rate_group_decoder i_rate_group_decoder_rogue (.hclk(hclk), .hresetn(hresetn), .link(bad),
    .rate_valid(rv2), .rate_group(rg2), .rate_min(rmin2), .rate_max(rmax2),
    .rate_step(rstp2), .block_done(bd2), .block_error(be2));
  rate_codec_asserts i_rate_codec_asserts (.hclk(hclk), .hresetn(hresetn),
    .oct_valid(link.oct_valid), .oct_data(link.oct_data), .oct_last(link.oct_last),
    .rate_valid(rv), .rate_group(rg), .rate_min(rmin), .rate_max(rmax), .rate_step(rstp),
    .block_done(bd), .block_error(be));

  // ----------------------------------------
  // clock, timeout, compare and verdict
  // ----------------------------------------
  always #5 hclk = ~hclk;
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch = n_mismatch + 1;
      print_verdict();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks = checks + 1;
    if (seen !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("mismatches=%0d checks=%0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // ----------------------------------------
  // expected octets and link monitor
  // ----------------------------------------
  function automatic logic [7:0] exp_oct(input rate_group_t g, input int p);
    case (p)
      0: return {5'h0, g.step[6], g.max[6], g.min[6]};
      1: return {2'h0, g.min[5:0]};
      2: return {2'h0, g.max[5:0]};
      default: return {2'h0, g.step[5:0]};
    endcase
  endfunction
  // negedge sampling: every registered output has settled by then
  always @(negedge hclk) begin
    if (link.oct_valid === 1'b1) begin
      check(link.oct_data, exp_oct(tbl[exp_w / 4], exp_w % 4));
      check(link.oct_last, exp_w == 4 * last + 3);
      exp_w = exp_w + 1;
    end
    if (rv === 1'b1) begin
      check(rg, exp_g);
      check({rstp, rmax, rmin}, tbl[exp_g]);
      exp_g = exp_g + 1;
    end
    if (bd === 1'b1) begin
      dones = dones + 1;
      check(be, 0);
    end
  end

  // ----------------------------------------
  // ahb-lite master and rogue link driver
  // ----------------------------------------
  task automatic wait_ready();
    do @(negedge hclk); while (hreadyout !== 1'b1);
    rd_s = hrdata;
    @(posedge hclk);
  endtask
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= HTRANS_NONSEQ;
    hsize <= HSIZE_WORD;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
  endtask
  task automatic send_bad(input logic [7:0] d, input logic l);
    bad.oct_valid <= 1'b1;
    bad.oct_data <= d;
    bad.oct_last <= l;
    @(posedge hclk);
  endtask
  task automatic idle_bad();
    bad.oct_valid <= 1'b0;
    bad.oct_last <= 1'b0;
    bad.oct_data <= ~bad.oct_data;
    @(negedge hclk);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {hclk, hresetn, hsel, hwrite, haddr, htrans, hsize, hwdata} = '0;
    {bad.oct_valid, bad.oct_data, bad.oct_last} = '0;
    {n_mismatch, checks, cyc, exp_g, exp_w, dones} = '0;
    last = 3'h0;
    void'($urandom(49523));
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    ahb(0, 32'(STATUS_OFS), 0);
    check(rd_s, 0);
    check(hresp, 1'b0);
    ahb(0, 32'h08, 0);
    check(rd_s, 0);
    for (int it = 0; it < 12; it++) begin
      last = (it < 2) ? 3'h7 : 3'($urandom_range(7));
      for (int g = 0; g <= int'(last); g++) begin
        tbl[g] = (it == 0) ? '0 : (it == 1) ? '1 : 21'($urandom);
        ahb(1, 32'(TABLE_OFS) + 4 * g, {9'h0, tbl[g].step, 1'b0, tbl[g].max, 1'b0, tbl[g].min});
      end
      ahb(0, 32'(TABLE_OFS) + 4 * last, 0);
      check(rd_s, {9'h0, tbl[last].step, 1'b0, tbl[last].max, 1'b0, tbl[last].min});
      {exp_g, exp_w, dones} = '0;
      ahb(1, 32'(CTRL_OFS), {25'h0, last, 4'h1});
      // pokes land while busy only on blocks of three groups or more
      if (last > 3'h1) begin
        ahb(1, 32'(TABLE_OFS) + 28, 32'h005a5a5a);
        ahb(1, 32'(CTRL_OFS), 32'h1);
      end
      rd_s = 0;
      for (int k = 0; k < 60 && rd_s[STAT_DONE_BIT] !== 1'b1; k++) ahb(0, 32'(STATUS_OFS), 0);
      repeat (2) @(posedge hclk);
      check(rd_s, 32'h2);
      check(dones, 1);
      check(exp_g, last + 1);
      ahb(0, 32'(CTRL_OFS), 0);
      check(rd_s, {25'h0, last, 4'h0});
      ahb(1, 32'(STATUS_OFS), 32'h2);
      ahb(0, 32'(STATUS_OFS), 0);
      check(rd_s, 0);
    end
    send_bad(8'h01, 0);
    send_bad(8'h02, 0);
    send_bad(8'h03, 0);
    send_bad(8'h04, 0);
    send_bad(8'h05, 0);
    send_bad(8'h06, 1);
    idle_bad();
    check({bd2, be2}, 2'b11);
    @(posedge hclk);
    send_bad(8'hff, 0);
    send_bad(8'hd5, 0);
    send_bad(8'h6a, 0);
    send_bad(8'hff, 1);
    idle_bad();
    check({rv2, bd2, be2, rg2}, 6'b110000);
    check({rstp2, rmax2, rmin2}, {7'h7f, 7'h6a, 7'h55});
    print_verdict();
  end
endmodule // tb_downstream_rate_field_codec

`default_nettype wire
